// File: pmbsc_regs.svh
`ifndef PMBSC_REGS_SVH
`define PMBSC_REGS_SVH
// fixed upper address bits
`define PMBSC_ADDR_HI 3'h1
// command codes
`define PMBSC_CMD_OPERATION 8'h01
`define PMBSC_CMD_ONOFF_CFG 8'h02
`define PMBSC_CMD_CLEAR 8'h03
`define PMBSC_CMD_WPROT 8'h10
`define PMBSC_CMD_SAVE 8'h11
`define PMBSC_CMD_LOAD 8'h12
`define PMBSC_CMD_STATUS 8'h79
`define PMBSC_CMD_USER_BASE 8'hD0
`define PMBSC_NUM_USER 7
// write-lock values
`define PMBSC_WP_ALL 8'h80
`define PMBSC_WP_OPER 8'h40
`define PMBSC_WP_CFG 8'h20
`define PMBSC_WP_NONE 8'h00
// reset values
`define PMBSC_OPER_RST 8'h00
`define PMBSC_ONOFF_RST 8'h17
// status bit positions
`define PMBSC_STAT_CML 1
// divider ratio thresholds, ratio scaled by 10000 (adc code 0..9999)
`define PMBSC_ADC_W 14
`define PMBSC_STRAP_SETTLE 16'h0010
`endif

// File: pmbsc_pkg.sv
package pmbsc_pkg;
    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
        logic sda;
    } pmbsc_bus_ev_t;
    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [7:0] data;
        logic has_data;
    } pmbsc_cmd_t;
endpackage : pmbsc_pkg

// File: pmbsc_line_sync.sv
`timescale 1ns/10ps
`include "pmbsc_regs.svh"
module pmbsc_line_sync
    import pmbsc_pkg::*;
(
    input wire logic clk_link,
    input wire logic reset_link,
    input wire logic scl_in,
    input wire logic sda_in,
    output pmbsc_bus_ev_t ev
);
    logic [1:0] scl_meta_reg;
    logic [1:0] sda_meta_reg;
    logic scl_last_reg;
    logic sda_last_reg;
    // ===========================================
    // two-flop synchroniser, first stage read only by second
    always_ff @(posedge clk_link) begin
        if (reset_link) begin
            scl_meta_reg <= 2'h3;
            sda_meta_reg <= 2'h3;
            scl_last_reg <= 1'b1;
            sda_last_reg <= 1'b1;
        end else begin
            scl_meta_reg <= {scl_meta_reg[0], scl_in};
            sda_meta_reg <= {sda_meta_reg[0], sda_in};
            scl_last_reg <= scl_meta_reg[1];
            sda_last_reg <= sda_meta_reg[1];
        end
    end
    // ===========================================
    // start, repeated start and stop seen while clock high
    always_comb begin
        ev.sda = sda_meta_reg[1];
        ev.rise = scl_meta_reg[1] & ~scl_last_reg;
        ev.fall = ~scl_meta_reg[1] & scl_last_reg;
        ev.start = scl_meta_reg[1] & scl_last_reg & sda_last_reg & ~sda_meta_reg[1];
        ev.stop = scl_meta_reg[1] & scl_last_reg & ~sda_last_reg & sda_meta_reg[1];
    end
endmodule : pmbsc_line_sync

// File: pmbsc_addr_strap.sv
`timescale 1ns/10ps
`include "pmbsc_regs.svh"
module pmbsc_addr_strap
    import pmbsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic supply_ok,
    input wire logic [13:0] strap_ratio,
    output logic [3:0] addr_low,
    output logic addr_valid
);
    logic [1:0] ok_meta_reg;
    logic [15:0] settle_reg;
    logic [13:0] ratio_reg;

    // ratio in units of 1/10000; bounds sit between the windows
    function automatic logic [3:0] ratio_to_addr(input logic [13:0] r);
        logic [3:0] a;
        a = 4'h0;
        if (r > 14'd5400) a = 4'hF;
        else if (r > 14'd4865) a = 4'hE;
        else if (r > 14'd4380) a = 4'hD;
        else if (r > 14'd3980) a = 4'hC;
        else if (r > 14'd3570) a = 4'hB;
        else if (r > 14'd3160) a = 4'hA;
        else if (r > 14'd2815) a = 4'h9;
        else if (r > 14'd2470) a = 4'h8;
        else if (r > 14'd2130) a = 4'h7;
        else if (r > 14'd1785) a = 4'h6;
        else if (r > 14'd1440) a = 4'h5;
        else if (r > 14'd1100) a = 4'h4;
        else if (r > 14'd0810) a = 4'h3;
        else if (r > 14'd0550) a = 4'h2;
        else if (r > 14'd0200) a = 4'h1;
        return a;
    endfunction : ratio_to_addr

    // ===========================================
    // strap read once after lockout releases, then held
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ok_meta_reg <= 2'h0;
            settle_reg <= 16'h0000;
            ratio_reg <= 14'h0000;
            addr_low <= 4'h0;
            addr_valid <= 1'b0;
        end else begin
            ok_meta_reg <= {ok_meta_reg[0], supply_ok};
            ratio_reg <= strap_ratio;
            if (!ok_meta_reg[1]) begin
                settle_reg <= 16'h0000;
                addr_valid <= 1'b0;
            end else if (!addr_valid) begin
                if (settle_reg == `PMBSC_STRAP_SETTLE) begin
                    addr_low <= ratio_to_addr(ratio_reg);
                    addr_valid <= 1'b1;
                end else begin
                    settle_reg <= settle_reg + 16'h0001;
                end
            end
        end
    end
endmodule : pmbsc_addr_strap

// File: pmbsc_cmd_port.sv
`timescale 1ns/10ps
`include "pmbsc_regs.svh"
// Functional notes
// - seven byte-wide user registers, individually reachable
// - direct writes; combined and stop-separated reads
// - no pointer auto-increment; any order
// - start/stop framing; repeated start handled
// - works at standard and fast rates
// - address 001 plus four strap bits
// - strap evaluated after lockout release only
// - divider ratio decodes to address bits
// - address lsb selects read or write
// - ack address, command and data on writes
// - combined read returns byte, host NACKs
// - pointer survives stop for later read
// - clear, save, load carry no data
// - save copies user registers to cells
// - load copies cells to user registers
// - status word is read-only
// - on/off command only switches converter
// - fault-clear resets all latched flags
// - write-lock governs writable commands
// - unsupported commands acked, no register written
// - unsupported command sets fault flag, alert
// - top-bit lock blocks all data writes but itself; clear, save, load still act
// - clear releases alert; present fault re-sets
module pmbsc_cmd_port
    import pmbsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_link,
    input wire logic reset_link,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic alert_n_out,
    output logic alert_n_oe,
    input wire logic supply_ok,
    input wire logic [13:0] strap_ratio,
    input wire logic [7:0] fault_status,
    output logic converter_on,
    output logic [7:0] onoff_cfg,
    output logic [55:0] user_cfg,
    output logic [3:0] addr_low,
    output logic addr_valid
);
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_ADDR = 6'b000010,
        ST_CMD = 6'b000100,
        ST_DATA = 6'b001000,
        ST_SEND = 6'b010000,
        ST_SKIP = 6'b100000
    } pmbsc_state_t;

    pmbsc_bus_ev_t ev;
    pmbsc_state_t state_reg;
    logic [7:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic ack_phase_reg;
    logic drive_low_reg;
    logic [7:0] ptr_reg;
    logic got_data_reg;
    logic [7:0] rx_code_reg;
    logic [7:0] rx_data_reg;
    logic rx_has_data_reg;
    logic rx_toggle_reg;
    logic [7:0] tx_byte_reg;
    logic [1:0] addr_meta_reg;
    logic [4:0] addr_sync_reg;
    logic [1:0] tog_meta_reg;
    logic tog_last_reg;
    logic [7:0] rd_byte_reg;
    logic [7:0] oper_reg;
    logic [7:0] wp_reg;
    logic [7:0] nv_cells [0:`PMBSC_NUM_USER-1];
    logic [7:0] user_reg [0:`PMBSC_NUM_USER-1];
    logic cml_reg;
    logic [7:0] flags_reg;
    logic [7:0] fault_meta_reg;
    logic [7:0] fault_sync_reg;
    pmbsc_cmd_t cmd;
    logic [3:0] addr_low_sys;
    logic addr_valid_sys;

    pmbsc_line_sync u_sync (
        .clk_link(clk_link),
        .reset_link(reset_link),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .ev(ev)
    );

    pmbsc_addr_strap u_strap (
        .clk_sys(clk_sys),
        .reset(reset),
        .supply_ok(supply_ok),
        .strap_ratio(strap_ratio),
        .addr_low(addr_low_sys),
        .addr_valid(addr_valid_sys)
    );

    // user register index of a command code, 7 when not a user register
    function automatic logic [2:0] user_index(input logic [7:0] code);
        logic [7:0] off;
        off = code - `PMBSC_CMD_USER_BASE;
        return (off < 8'(`PMBSC_NUM_USER)) ? off[2:0] : 3'h7;
    endfunction : user_index

    function automatic logic code_supported(input logic [7:0] code);
        return (user_index(code) != 3'h7) || code == `PMBSC_CMD_OPERATION ||
            code == `PMBSC_CMD_ONOFF_CFG || code == `PMBSC_CMD_CLEAR ||
            code == `PMBSC_CMD_WPROT || code == `PMBSC_CMD_SAVE ||
            code == `PMBSC_CMD_LOAD || code == `PMBSC_CMD_STATUS;
    endfunction : code_supported

    // ===========================================
    // link domain: address and read byte brought over
    // both change rarely and are held stable; valid takes two flops, address and byte one capture flop
    always_ff @(posedge clk_link) begin
        if (reset_link) begin
            addr_meta_reg <= 2'h0;
            addr_sync_reg <= 5'h00;
            tx_byte_reg <= 8'h00;
        end else begin
            addr_meta_reg <= {addr_meta_reg[0], addr_valid_sys};
            if (addr_meta_reg[1]) begin
                addr_sync_reg <= {1'b1, addr_low_sys};
            end
            if (state_reg == ST_IDLE || state_reg == ST_ADDR) begin
                tx_byte_reg <= rd_byte_reg;
            end
        end
    end

    // ===========================================
    // link domain: byte engine
    always_ff @(posedge clk_link) begin
        if (reset_link) begin
            state_reg <= ST_IDLE;
            shift_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
            ack_phase_reg <= 1'b0;
            drive_low_reg <= 1'b0;
            got_data_reg <= 1'b0;
            rx_code_reg <= 8'h00;
            rx_data_reg <= 8'h00;
            rx_has_data_reg <= 1'b0;
            rx_toggle_reg <= 1'b0;
        end else if (ev.start) begin
            // repeated start ends any write phase without data
            if (state_reg == ST_DATA && !got_data_reg) begin
                rx_has_data_reg <= 1'b0;
                rx_toggle_reg <= ~rx_toggle_reg;
            end
            state_reg <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
            ack_phase_reg <= 1'b0;
            drive_low_reg <= 1'b0;
        end else if (ev.stop) begin
            if (state_reg == ST_DATA && !got_data_reg) begin
                rx_has_data_reg <= 1'b0;
                rx_toggle_reg <= ~rx_toggle_reg;
            end
            state_reg <= ST_IDLE;
            drive_low_reg <= 1'b0;
        end else if (ev.rise && !ack_phase_reg && state_reg != ST_IDLE) begin
            shift_reg <= {shift_reg[6:0], ev.sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end else if (ev.rise && ack_phase_reg && state_reg == ST_SEND && ev.sda) begin
            state_reg <= ST_IDLE;
        end else if (ev.fall) begin
            if (ack_phase_reg) begin
                ack_phase_reg <= 1'b0;
                bit_cnt_reg <= 4'h0;
                drive_low_reg <= (state_reg == ST_SEND) ? ~tx_byte_reg[7] : 1'b0;
            end else if (state_reg == ST_SEND) begin
                if (bit_cnt_reg == 4'h8) begin
                    drive_low_reg <= 1'b0;
                    ack_phase_reg <= 1'b1;
                end else begin
                    drive_low_reg <= ~tx_byte_reg[3'h7 - bit_cnt_reg[2:0]];
                end
            end else if (bit_cnt_reg == 4'h8) begin
                ack_phase_reg <= 1'b1;
                case (state_reg)
                    ST_ADDR: begin
                        if (addr_sync_reg[4] &&
                            shift_reg[7:1] == {`PMBSC_ADDR_HI, addr_sync_reg[3:0]}) begin
                            drive_low_reg <= 1'b1;
                            state_reg <= shift_reg[0] ? ST_SEND : ST_CMD;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                    ST_CMD: begin
                        drive_low_reg <= 1'b1;
                        rx_code_reg <= shift_reg;
                        got_data_reg <= 1'b0;
                        state_reg <= ST_DATA;
                    end
                    ST_DATA: begin
                        drive_low_reg <= 1'b1;
                        rx_data_reg <= shift_reg;
                        rx_has_data_reg <= 1'b1;
                        got_data_reg <= 1'b1;
                        rx_toggle_reg <= ~rx_toggle_reg;
                        state_reg <= ST_SKIP;
                    end
                    ST_SKIP: begin
                        drive_low_reg <= 1'b1;
                    end
                    default: begin
                        drive_low_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    always_comb begin
        sda_out = 1'b0;
        sda_oe = drive_low_reg;
    end

    // ===========================================
    // system domain: toggle crossing of finished commands
    // code is stable a whole byte time before the toggle flips on a data write, only the ack bit before a stop flip; data is loaded with the flip
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tog_meta_reg <= 2'h0;
            tog_last_reg <= 1'b0;
        end else begin
            tog_meta_reg <= {tog_meta_reg[0], rx_toggle_reg};
            tog_last_reg <= tog_meta_reg[1];
        end
    end

    always_comb begin
        cmd.valid = tog_meta_reg[1] ^ tog_last_reg;
        cmd.code = rx_code_reg;
        cmd.data = rx_data_reg;
        cmd.has_data = rx_has_data_reg;
    end

    function automatic logic write_allowed(input logic [7:0] code, input logic [7:0] wp);
        logic ok;
        ok = 1'b0;
        if (code == `PMBSC_CMD_WPROT) ok = 1'b1;
        else if (wp == `PMBSC_WP_NONE) ok = 1'b1;
        else if (wp == `PMBSC_WP_CFG) ok = code == `PMBSC_CMD_OPERATION ||
            code == `PMBSC_CMD_ONOFF_CFG;
        else if (wp == `PMBSC_WP_OPER) ok = code == `PMBSC_CMD_OPERATION;
        return ok;
    endfunction : write_allowed

    // ===========================================
    // system domain: register file
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            oper_reg <= `PMBSC_OPER_RST;
            onoff_cfg <= `PMBSC_ONOFF_RST;
            wp_reg <= `PMBSC_WP_NONE;
            for (int i = 0; i < `PMBSC_NUM_USER; i++) begin
                user_reg[i] <= 8'h00;
                nv_cells[i] <= 8'h00;
            end
        end else if (cmd.valid && code_supported(cmd.code)) begin
            if (!cmd.has_data) begin
                if (cmd.code == `PMBSC_CMD_SAVE) begin
                    for (int i = 0; i < `PMBSC_NUM_USER; i++) begin
                        nv_cells[i] <= user_reg[i];
                    end
                end else if (cmd.code == `PMBSC_CMD_LOAD) begin
                    for (int i = 0; i < `PMBSC_NUM_USER; i++) begin
                        user_reg[i] <= nv_cells[i];
                    end
                end
            end else if (write_allowed(cmd.code, wp_reg)) begin
                if (cmd.code == `PMBSC_CMD_OPERATION) begin
                    oper_reg <= {cmd.data[7], 7'h00};
                end else if (cmd.code == `PMBSC_CMD_ONOFF_CFG) begin
                    onoff_cfg <= {4'h1, cmd.data[3:2], 2'h3};
                end else if (cmd.code == `PMBSC_CMD_WPROT) begin
                    wp_reg <= cmd.data;
                end else if (user_index(cmd.code) != 3'h7) begin
                    user_reg[user_index(cmd.code)] <= cmd.data;
                end
            end
        end
    end

    // ===========================================
    // system domain: flags, alert and read data
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fault_meta_reg <= 8'h00;
            fault_sync_reg <= 8'h00;
            flags_reg <= 8'h00;
            cml_reg <= 1'b0;
            ptr_reg <= 8'h00;
        end else begin
            fault_meta_reg <= fault_status;
            fault_sync_reg <= fault_meta_reg;
            if (cmd.valid) ptr_reg <= cmd.code;
            if (cmd.valid && !cmd.has_data && cmd.code == `PMBSC_CMD_CLEAR) begin
                flags_reg <= fault_sync_reg;
                cml_reg <= 1'b0;
            end else begin
                flags_reg <= flags_reg | fault_sync_reg;
                if (cmd.valid && !code_supported(cmd.code)) begin
                    cml_reg <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rd_byte_reg <= 8'h00;
        end else if (ptr_reg == `PMBSC_CMD_OPERATION) begin
            rd_byte_reg <= oper_reg;
        end else if (ptr_reg == `PMBSC_CMD_ONOFF_CFG) begin
            rd_byte_reg <= onoff_cfg;
        end else if (ptr_reg == `PMBSC_CMD_WPROT) begin
            rd_byte_reg <= wp_reg;
        end else if (ptr_reg == `PMBSC_CMD_STATUS) begin
            rd_byte_reg <= flags_reg | {6'h00, cml_reg, 1'b0};
        end else if (user_index(ptr_reg) != 3'h7) begin
            rd_byte_reg <= user_reg[user_index(ptr_reg)];
        end else begin
            rd_byte_reg <= 8'h00;
        end
    end

    always_comb begin
        alert_n_out = 1'b0;
        alert_n_oe = cml_reg | (|flags_reg);
        converter_on = oper_reg[7];
        addr_low = addr_low_sys;
        addr_valid = addr_valid_sys;
        for (int i = 0; i < `PMBSC_NUM_USER; i++) begin
            user_cfg[i*8 +: 8] = user_reg[i];
        end
    end
endmodule : pmbsc_cmd_port

// File: pmbsc_cmd_port_chk.sv
`timescale 1ns/10ps
// ==========
// port checker
module pmbsc_cmd_port_chk (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_link,
    input wire logic reset_link,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic alert_n_out,
    input wire logic supply_ok,
    input wire logic [13:0] strap_ratio,
    input wire logic converter_on,
    input wire logic [7:0] onoff_cfg,
    input wire logic [55:0] user_cfg,
    input wire logic [3:0] addr_low,
    input wire logic addr_valid
);
    logic [55:0] prev_reg;
    logic [6:0] lane_chg;
    always_ff @(posedge clk_sys) begin
        prev_reg <= user_cfg;
    end
    // load may touch many lanes; the bench keeps cells equal to all but one
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            lane_chg[i] = |(user_cfg[i*8 +: 8] ^ prev_reg[i*8 +: 8]);
        end
    end
    AST_ADDR_WAIT: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(addr_valid) |-> $past(supply_ok, 16)) else $error("strap read before supply ok");
    AST_ADDR_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
        addr_valid |=> addr_valid && $stable(addr_low)) else $error("address moved");
    AST_ADDR_WINDOW: assert property (@(posedge clk_sys) disable iff (reset)
        addr_valid && strap_ratio >= 14'h135E && strap_ratio <= 14'h147F |-> addr_low == 4'hE)
        else $error("ratio decode wrong");
    AST_OE_SCL_LOW: assert property (@(posedge clk_link) disable iff (reset_link)
        $changed(sda_oe) |-> !scl_in) else $error("sda moved while scl high");
    AST_NO_ACK_EARLY: assert property (@(posedge clk_link) disable iff (reset_link)
        !addr_valid |-> !sda_oe) else $error("drive before address known");
    AST_OPEN_DRAIN: assert property (@(posedge clk_sys) disable iff (reset)
        sda_out == 1'b0 && alert_n_out == 1'b0) else $error("pin driven high");
    AST_RESET_VALUES: assert property (@(posedge clk_sys) disable iff (reset)
        $fell(reset) |-> onoff_cfg == 8'h17 && !converter_on && user_cfg == 56'h0)
        else $error("bad reset value");
    AST_ONE_LANE: assert property (@(posedge clk_sys) disable iff (reset)
        $onehot0(lane_chg)) else $error("more than one register changed");
endmodule : pmbsc_cmd_port_chk

bind pmbsc_cmd_port pmbsc_cmd_port_chk u_chk (.clk_sys(clk_sys), .reset(reset),
    .clk_link(clk_link), .reset_link(reset_link), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .alert_n_out(alert_n_out), .supply_ok(supply_ok),
    .strap_ratio(strap_ratio), .converter_on(converter_on), .onoff_cfg(onoff_cfg),
    .user_cfg(user_cfg), .addr_low(addr_low), .addr_valid(addr_valid));

// File: pmbsc_host_model.sv
`timescale 1ns/10ps
// ==========
// bus host master
module pmbsc_host_model (
    input wire logic clk_link,
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    int half = 10;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_link);
    endtask : tick
    // serves idle start and repeated start alike
    task automatic bus_start();
        sda_low <= 1'b0;
        tick(half);
        scl <= 1'b1;
        tick(half);
        sda_low <= 1'b1;
        tick(half);
        scl <= 1'b0;
        tick(2);
    endtask : bus_start
    task automatic bus_stop();
        sda_low <= 1'b1;
        tick(half);
        scl <= 1'b1;
        tick(half);
        sda_low <= 1'b0;
        tick(half);
    endtask : bus_stop
    // sampled just before the fall, where an ack still stands
    task automatic clock_bit(input logic b, output logic s);
        sda_low <= ~b;
        tick(half);
        scl <= 1'b1;
        tick(half);
        s = sda_line;
        scl <= 1'b0;
        tick(2);
    endtask : clock_bit
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], s);
        end
        clock_bit(1'b1, s);
        ack = ~s;
    endtask : send_byte
    task automatic recv_byte(output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, s);
            d[i] = s;
        end
        clock_bit(1'b1, s);
    endtask : recv_byte
endmodule : pmbsc_host_model

// File: tb_top.sv
`timescale 1ns/10ps
`include "pmbsc_regs.svh"
module tb_top;
    logic clk_sys = 1'b0;
    logic clk_link = 1'b0;
    logic reset = 1'b1;
    logic reset_link = 1'b1;
    logic supply_ok = 1'b0;
    logic [13:0] strap_ratio = 14'h13EC;
    logic [7:0] fault_status = 8'h00;
    logic scl_in, sda_in, sda_out, sda_oe, alert_n_out, alert_n_oe, host_low;
    logic converter_on, addr_valid;
    logic [7:0] onoff_cfg;
    logic [55:0] user_cfg;
    logic [3:0] addr_low;
    int mismatches = 0;
    int n_tests = 0;
    localparam logic [7:0] ADDR_W = 8'h3C;
    localparam logic [7:0] ADDR_R = 8'h3D;
    always #5 clk_sys = ~clk_sys;
    // link clock offset from system clock edges
    initial begin
        #1.7;
        forever #3 clk_link = ~clk_link;
    end
    // wired-and with pull-up
    assign sda_in = ~(host_low | sda_oe);
    pmbsc_cmd_port u_pmbsc_cmd_port (.clk_sys(clk_sys), .reset(reset), .clk_link(clk_link),
        .reset_link(reset_link), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
        .sda_oe(sda_oe), .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe),
        .supply_ok(supply_ok), .strap_ratio(strap_ratio), .fault_status(fault_status),
        .converter_on(converter_on), .onoff_cfg(onoff_cfg), .user_cfg(user_cfg),
        .addr_low(addr_low), .addr_valid(addr_valid));
    pmbsc_host_model u_host (.clk_link(clk_link), .sda_line(sda_in), .scl(scl_in),
        .sda_low(host_low));
    // ==========
    // shared tasks
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic put(input logic [7:0] b, input logic exp);
        logic a;
        u_host.send_byte(b, a);
        check("ack", {63'h0, a}, {63'h0, exp});
    endtask : put
    task automatic wr(input logic [7:0] cmd, input logic [7:0] data, input bit with_data);
        u_host.bus_start();
        put(ADDR_W, 1'b1);
        put(cmd, 1'b1);
        if (with_data) begin
            put(data, 1'b1);
        end
        u_host.bus_stop();
        repeat (12) @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [7:0] cmd, input bit combined, output logic [7:0] d);
        u_host.bus_start();
        put(ADDR_W, 1'b1);
        put(cmd, 1'b1);
        if (!combined) begin
            u_host.bus_stop();
            u_host.bus_start();
            put(8'h20, 1'b0);
            u_host.bus_stop();
        end
        u_host.bus_start();
        put(ADDR_R, 1'b1);
        u_host.recv_byte(d);
        u_host.bus_stop();
        repeat (12) @(posedge clk_sys);
    endtask : rd
    // ==========
    // scenarios
    task automatic t_addr();
        repeat (40) @(posedge clk_sys);
        check("addr_valid", {63'h0, addr_valid}, 64'h0);
        supply_ok <= 1'b1;
        for (int i = 0; i < 200 && addr_valid !== 1'b1; i++) begin
            @(posedge clk_sys);
        end
        check("addr_low", {60'h0, addr_low}, 64'hE);
        repeat (20) @(posedge clk_sys);
        $display("t_addr done");
    endtask : t_addr
    task automatic t_regs();
        logic [7:0] d;
        wr(8'hD3, 8'hA5, 1'b1);
        wr(8'hD5, 8'h3C, 1'b1);
        check("user_cfg", {8'h0, user_cfg}, 64'h003C00A5000000);
        rd(8'hD3, 1'b1, d);
        check("comb", {56'h0, d}, 64'hA5);
        rd(8'hD5, 1'b0, d);
        check("sep", {56'h0, d}, 64'h3C);
        rd(8'hD3, 1'b0, d);
        check("sep2", {56'h0, d}, 64'hA5);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_nvm();
        wr(8'hD0, 8'h11, 1'b1);
        wr(`PMBSC_CMD_SAVE, 8'h00, 1'b0);
        wr(8'hD0, 8'h22, 1'b1);
        check("d0", {56'h0, user_cfg[7:0]}, 64'h22);
        wr(`PMBSC_CMD_LOAD, 8'h00, 1'b0);
        check("load", {8'h0, user_cfg}, 64'h003C00A5000011);
        $display("t_nvm done");
    endtask : t_nvm
    task automatic t_lock();
        wr(`PMBSC_CMD_WPROT, `PMBSC_WP_ALL, 1'b1);
        wr(8'hD1, 8'h55, 1'b1);
        wr(`PMBSC_CMD_OPERATION, 8'h80, 1'b1);
        check("lock_on", {63'h0, converter_on}, 64'h0);
        wr(`PMBSC_CMD_WPROT, `PMBSC_WP_OPER, 1'b1);
        wr(8'hD1, 8'h55, 1'b1);
        wr(`PMBSC_CMD_OPERATION, 8'h80, 1'b1);
        check("lock_cfg", {8'h0, user_cfg}, 64'h003C00A5000011);
        check("oper_on", {63'h0, converter_on}, 64'h1);
        wr(`PMBSC_CMD_WPROT, `PMBSC_WP_NONE, 1'b1);
        wr(`PMBSC_CMD_ONOFF_CFG, 8'h00, 1'b1);
        wr(`PMBSC_CMD_OPERATION, 8'h00, 1'b1);
        check("oper_off", {63'h0, converter_on}, 64'h0);
        check("onoff_cfg", {56'h0, onoff_cfg}, 64'h13);
        $display("t_lock done");
    endtask : t_lock
    task automatic t_fault();
        logic [7:0] d;
        check("alert_idle", {63'h0, alert_n_oe}, 64'h0);
        wr(8'h55, 8'h77, 1'b1);
        check("ignored", {8'h0, user_cfg}, 64'h003C00A5000011);
        check("alert", {63'h0, alert_n_oe}, 64'h1);
        wr(`PMBSC_CMD_STATUS, 8'hFF, 1'b1);
        rd(`PMBSC_CMD_STATUS, 1'b1, d);
        check("status", {56'h0, d}, 64'h02);
        fault_status <= 8'h10;
        wr(`PMBSC_CMD_CLEAR, 8'h00, 1'b0);
        rd(`PMBSC_CMD_STATUS, 1'b1, d);
        check("refault", {56'h0, d}, 64'h10);
        check("realert", {63'h0, alert_n_oe}, 64'h1);
        fault_status <= 8'h00;
        wr(`PMBSC_CMD_CLEAR, 8'h00, 1'b0);
        rd(`PMBSC_CMD_STATUS, 1'b0, d);
        check("cleared", {56'h0, d}, 64'h00);
        check("released", {63'h0, alert_n_oe}, 64'h0);
        $display("t_fault done");
    endtask : t_fault
    task automatic t_rate();
        u_host.half = 833;
        wr(8'hD6, 8'h5A, 1'b1);
        u_host.half = 208;
        wr(8'hD2, 8'hC3, 1'b1);
        u_host.half = 10;
        check("rates", {8'h0, user_cfg}, 64'h5A3C00A5C30011);
        $display("t_rate done");
    endtask : t_rate
    initial begin
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_link);
        reset_link <= 1'b0;
        t_addr();
        t_regs();
        t_nvm();
        t_lock();
        t_fault();
        t_rate();
        tally_and_finish();
    end
    // about twice the expected run
    initial begin
        #900000;
        mismatches++;
        $display("[ERR] watchdog expected done seen hang");
        tally_and_finish();
    end
endmodule : tb_top
